// ==== logic/fcs_pkg.sv ====
package fcs_pkg;
    // ------------------------------------------------
    // map and codes
    // ------------------------------------------------
    localparam logic [15:0] CTRL_ADDR     = 16'h0fff;
    localparam logic [11:0] UNLK_ADDR1    = 12'h555;
    localparam logic [11:0] UNLK_ADDR2    = 12'haaa;
    localparam logic [15:0] ID_MAKER_ADDR = 16'hf000;
    localparam logic [15:0] ID_MACRO_ADDR = 16'hf001;
    localparam logic [15:0] ID_SIZE_ADDR  = 16'hf002;
    localparam logic [15:0] SEC_ADDR      = 16'hff7f;
    localparam logic [7:0]  CMD_UNLK1     = 8'haa;
    localparam logic [7:0]  CMD_UNLK2     = 8'h55;
    localparam logic [7:0]  CMD_PROG      = 8'ha0;
    localparam logic [7:0]  CMD_ERASE     = 8'h80;
    localparam logic [7:0]  CMD_SECT      = 8'h30;
    localparam logic [7:0]  CMD_CHIP      = 8'h10;
    localparam logic [7:0]  CMD_ID_ENTRY  = 8'h90;
    localparam logic [7:0]  CMD_ID_EXIT   = 8'hf0;
    localparam logic [7:0]  CMD_SECURE    = 8'ha5;
    localparam logic [7:0]  SEC_DATA      = 8'h00;
    localparam logic [7:0]  ERASED_BYTE   = 8'hff;
    localparam logic [7:0]  PROT_ON_BYTE  = 8'h00;
    localparam logic [7:0]  REFUSED_BYTE  = 8'h00;
    localparam logic [7:0]  SIZE_4K       = 8'h00;
    localparam logic [7:0]  SIZE_8K       = 8'h01;
    localparam logic [7:0]  SIZE_16K      = 8'h03;
    localparam logic [7:0]  SIZE_24K      = 8'h05;
    localparam logic [7:0]  SIZE_32K      = 8'h07;
    localparam logic [7:0]  SIZE_48K      = 8'h0b;
    localparam logic [7:0]  SIZE_60K      = 8'h0e;
    // ------------------------------------------------
    // control field
    // ------------------------------------------------
    localparam int          UNLOCK_LSB    = 4;
    localparam int          BANK_BIT      = 3;
    localparam logic [3:0]  UNLOCK_EN     = 4'h3;
    localparam logic [3:0]  UNLOCK_RST    = 4'hc;
    localparam logic        BANK_RST      = 1'b1;
    // ------------------------------------------------
    // timing
    // ------------------------------------------------
    localparam int CLK_PERIOD_NS  = 100;
    localparam int PROG_TIME_NS   = 40000;
    localparam int SEC_TIME_NS    = 40000;
    localparam int ERASE_TIME_NS  = 30000000;
    localparam int PROG_CYC       = PROG_TIME_NS / CLK_PERIOD_NS;
    localparam int SEC_CYC        = SEC_TIME_NS / CLK_PERIOD_NS;
    localparam int ERASE_CYC_DFLT = ERASE_TIME_NS / CLK_PERIOD_NS;
    localparam int TIMER_W        = 24;
    // ------------------------------------------------
    // types
    // ------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE, ST_C1, ST_C2, ST_PROG, ST_E3, ST_E4, ST_E5, ST_SEC
    } fcs_state_t;
    typedef enum logic [1:0] {
        OP_PROG, OP_SECT, OP_CHIP, OP_SEC
    } fcs_op_t;
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } fcs_bus_t;
endpackage : fcs_pkg

// ==== logic/fcs_sequencer.sv ====
`timescale 1ns/100ps
// Contract
// - unlock addresses compare low 12 bits; target, sector, security use full address
// - upper 4 address bits pick flash area; serial boot adds bank select
// - program: 555/AA, AAA/55, 555/A0, then target address and data
// - sector erase: five unlock writes then sector address with 30; erases 4 kbytes
// - chip erase: sixth write 555/10; whole array then reads FF
// - 555/AA, AAA/55, 555/90 enters identification mode
// - identification exit by single F0 write or chain ending 555/F0
// - identification reads give maker, macro and size codes at F000-F002
// - size code is the number of 4-kbyte steps less one, 0E meaning 60 kbytes
// - identification read of FF7F gives FF when unprotected
// - security chain ends FF7F/00 and sets protection
// - protected: parallel reads refused, serial boot program and sector erase refused; chip erase still accepted
// - only a completed chip erase clears protection; the code also clears it at reset
// - byte program finishes within 40 us
// - sector erase finishes within 30 ms
// - chip erase takes about 30 ms
// - protection setting finishes within 40 us
// - no new chain accepted while an operation runs
// - busy reads flip busy_toggle_bit each time; stable afterwards
// - first toggle-bit read after program, chip erase or security is one
// - chains accepted only with command_unlock_field 0011; resets to 1100
// - serial boot bank 0 maps 1000-7FFF at 9000-FFFF, bank 1 direct
module fcs_sequencer #(
    parameter int unsigned ERASE_CYC  = fcs_pkg::ERASE_CYC_DFLT,
    parameter logic [7:0]  MAKER_CODE = 8'h5a,  // arbitrary value
    parameter logic [7:0]  MACRO_CODE = 8'h3c,  // arbitrary value
    parameter logic [7:0]  SIZE_CODE  = fcs_pkg::SIZE_60K
) (
    // clock and reset
    input  wire logic             sys_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             clk_en_in,
    // cpu bus
    input  wire fcs_pkg::fcs_bus_t bus_in,
    output logic [7:0]            rdata_out,
    // mode pins
    input  wire logic             serial_boot_in,
    input  wire logic             parallel_mode_in,
    // status
    output logic                  busy_out,
    output logic                  id_mode_out,
    output logic                  protect_out,
    output logic                  loader_block_out
);
    import fcs_pkg::*;

    // ------------------------------------------------
    // declarations
    // ------------------------------------------------
    logic [1:0]         mode_s1_q;
    logic [1:0]         mode_s2_q;
    logic [3:0]         unlock_q;
    logic               bank_q;
    fcs_state_t         state_q;
    fcs_state_t         state_d;
    fcs_op_t            op_q;
    fcs_op_t            op_d;
    logic               busy_q;
    logic               id_q;
    logic               prot_q;
    logic               tog_q;
    logic [TIMER_W-1:0] timer_q;
    logic [TIMER_W-1:0] timer_ld;
    logic [15:0]        ptr_q;
    logic               sweep_done_q;
    logic [15:0]        prog_addr_q;
    logic [7:0]         prog_data_q;
    logic [7:0]         rdata_q;
    logic [7:0]         array_mem [0:65535];
    logic               start_d;
    logic               id_set_d;
    logic               id_clr_d;

    wire                serial_w  = mode_s2_q[0];
    wire                par_w     = mode_s2_q[1];
    wire                wr_w      = bus_in.wr & clk_en_in;
    wire                rd_w      = bus_in.rd & clk_en_in;
    wire [15:0]         addr_w    = bus_in.addr;
    wire [7:0]          data_w    = bus_in.wdata;

    // ------------------------------------------------
    // address decode
    // ------------------------------------------------
    wire bank_area_w = addr_w[15] & (bank_q | (addr_w[14:12] != 3'h0));
    wire in_flash_w  = serial_w ? bank_area_w
                                : (addr_w[15:12] != 4'h0);
    wire [15:0] phys_w = (serial_w && !bank_q) ? {1'b0, addr_w[14:0]}
                                               : addr_w;
    wire hit1_w = (addr_w[11:0] == UNLK_ADDR1);
    wire hit2_w = (addr_w[11:0] == UNLK_ADDR2);
    wire cmd_ok_w = (unlock_q == UNLOCK_EN) && !busy_q;
    wire cmd_wr_w = wr_w && cmd_ok_w && in_flash_w;
    wire ctrl_wr_w = wr_w && (addr_w == CTRL_ADDR);
    wire blocked_w = prot_q && serial_w;
    wire erasing_w = (op_q == OP_SECT) || (op_q == OP_CHIP);
    wire done_w = busy_q && (timer_q == '0) && sweep_done_q;
    wire sweep_last_w = (op_q == OP_CHIP) ? (ptr_q == 16'hffff)
                                          : (ptr_q[11:0] == 12'hfff);

    // ------------------------------------------------
    // command chain decoder
    // ------------------------------------------------
    always_comb begin
        state_d  = state_q;
        op_d     = op_q;
        start_d  = 1'b0;
        id_set_d = 1'b0;
        id_clr_d = 1'b0;
        if (cmd_wr_w) begin
            state_d = ST_IDLE;
            case (state_q)
                ST_IDLE: begin
                    if (hit1_w && data_w == CMD_UNLK1) begin
                        state_d = ST_C1;
                    end
                    if (data_w == CMD_ID_EXIT) begin
                        id_clr_d = 1'b1;
                    end
                end
                ST_C1: begin
                    if (hit2_w && data_w == CMD_UNLK2) begin
                        state_d = ST_C2;
                    end
                end
                ST_C2: begin
                    if (hit1_w) begin
                        case (data_w)
                            CMD_PROG:     state_d = ST_PROG;
                            CMD_ERASE:    state_d = ST_E3;
                            CMD_SECURE:   state_d = ST_SEC;
                            CMD_ID_ENTRY: id_set_d = 1'b1;
                            CMD_ID_EXIT:  id_clr_d = 1'b1;
                            default:      state_d = ST_IDLE;
                        endcase
                    end
                end
                ST_PROG: begin
                    if (!blocked_w) begin
                        start_d = 1'b1;
                        op_d    = OP_PROG;
                    end
                end
                ST_E3: begin
                    if (hit1_w && data_w == CMD_UNLK1) begin
                        state_d = ST_E4;
                    end
                end
                ST_E4: begin
                    if (hit2_w && data_w == CMD_UNLK2) begin
                        state_d = ST_E5;
                    end
                end
                ST_E5: begin
                    if (data_w == CMD_SECT && !blocked_w) begin
                        start_d = 1'b1;
                        op_d    = OP_SECT;
                    end else if (hit1_w && data_w == CMD_CHIP) begin
                        start_d = 1'b1;
                        op_d    = OP_CHIP;
                    end
                end
                ST_SEC: begin
                    if (addr_w == SEC_ADDR && data_w == SEC_DATA) begin
                        start_d = 1'b1;
                        op_d    = OP_SEC;
                    end
                end
                default: state_d = ST_IDLE;
            endcase
        end else if (wr_w && cmd_ok_w && data_w == CMD_ID_EXIT) begin
            id_clr_d = 1'b1;
        end
    end

    // ------------------------------------------------
    // operation length
    // ------------------------------------------------
    always_comb begin
        case (op_d)
            OP_PROG: timer_ld = TIMER_W'(PROG_CYC - 1);
            OP_SEC:  timer_ld = TIMER_W'(SEC_CYC - 1);
            default: timer_ld = TIMER_W'(ERASE_CYC - 1);
        endcase
    end

    // ------------------------------------------------
    // mode pin synchronisers
    // ------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            mode_s1_q <= 2'h0;
            mode_s2_q <= 2'h0;
        end else if (clk_en_in) begin
            mode_s1_q <= {parallel_mode_in, serial_boot_in};
            mode_s2_q <= mode_s1_q;
        end
    end

    // ------------------------------------------------
    // control field and chain state
    // ------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            unlock_q <= UNLOCK_RST;
            bank_q   <= BANK_RST;
            state_q  <= ST_IDLE;
            id_q     <= 1'b0;
        end else begin
            if (ctrl_wr_w) begin
                unlock_q <= data_w[UNLOCK_LSB +: 4];
                bank_q   <= data_w[BANK_BIT];
            end
            state_q <= state_d;
            if (id_set_d) begin
                id_q <= 1'b1;
            end else if (id_clr_d) begin
                id_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------
    // operation engine
    // ------------------------------------------------
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            op_q         <= OP_PROG;
            busy_q       <= 1'b0;
            prot_q       <= 1'b0;
            tog_q        <= 1'b1;
            timer_q      <= '0;
            ptr_q        <= 16'h0;
            sweep_done_q <= 1'b1;
            prog_addr_q  <= 16'h0;
            prog_data_q  <= 8'h0;
        end else if (clk_en_in) begin
            if (start_d) begin
                op_q         <= op_d;
                busy_q       <= 1'b1;
                tog_q        <= 1'b1;
                timer_q      <= timer_ld;
                prog_addr_q  <= phys_w;
                prog_data_q  <= data_w;
                sweep_done_q <= !((op_d == OP_SECT) || (op_d == OP_CHIP));
                ptr_q        <= (op_d == OP_SECT) ? {phys_w[15:12], 12'h0}
                                                  : 16'h0;
            end else if (busy_q) begin
                if (timer_q != '0) begin
                    timer_q <= timer_q - TIMER_W'(1);
                end
                if (erasing_w && !sweep_done_q) begin
                    ptr_q        <= ptr_q + 16'h1;
                    sweep_done_q <= sweep_last_w;
                end
                if (rd_w) begin
                    tog_q <= ~tog_q;
                end
                if (done_w) begin
                    busy_q <= 1'b0;
                    if (op_q == OP_SEC) begin
                        prot_q <= 1'b1;
                    end else if (op_q == OP_CHIP) begin
                        prot_q <= 1'b0;
                    end
                end
            end
        end
    end

    // ------------------------------------------------
    // array write port
    // ------------------------------------------------
    wire        sweep_we_w = clk_en_in && busy_q && erasing_w && !sweep_done_q;
    wire        prog_we_w  = clk_en_in && done_w && (op_q == OP_PROG);
    wire [15:0] mem_wa_w   = sweep_we_w ? ptr_q : prog_addr_q;
    wire [7:0]  mem_wd_w   = sweep_we_w ? ERASED_BYTE
                                        : (array_mem[prog_addr_q] & prog_data_q);

    always_ff @(posedge sys_clk_in) begin
        if (sweep_we_w || prog_we_w) begin
            array_mem[mem_wa_w] <= mem_wd_w;
        end
    end

    // ------------------------------------------------
    // read path
    // ------------------------------------------------
    wire [7:0] ctrl_rd_w = {unlock_q, bank_q, busy_q, id_q, prot_q};
    wire [7:0] arr_w     = in_flash_w ? array_mem[phys_w] : 8'h00;
    wire [7:0] arr_tog_w = busy_q ? {arr_w[7], tog_q, arr_w[5:0]}
                                  : arr_w;
    wire [7:0] prot_rd_w = prot_q ? PROT_ON_BYTE : ERASED_BYTE;
    wire [7:0] rd_sel_w  =
        (addr_w == CTRL_ADDR)              ? ctrl_rd_w  :
        (id_q && addr_w == ID_MAKER_ADDR)  ? MAKER_CODE :
        (id_q && addr_w == ID_MACRO_ADDR)  ? MACRO_CODE :
        (id_q && addr_w == ID_SIZE_ADDR)   ? SIZE_CODE  :
        (id_q && addr_w == SEC_ADDR)       ? prot_rd_w  :
        (par_w && prot_q)                  ? REFUSED_BYTE :
                                             arr_tog_w;

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            rdata_q <= 8'h0;
        end else if (rd_w) begin
            rdata_q <= rd_sel_w;
        end
    end

    assign rdata_out        = rdata_q;
    assign busy_out         = busy_q;
    assign id_mode_out      = id_q;
    assign protect_out      = prot_q;
    assign loader_block_out = blocked_w;

    // ------------------------------------------------
    // assertions
    // ------------------------------------------------
    logic [TIMER_W-1:0] busy_cnt_q;
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in || !busy_q) begin
            busy_cnt_q <= '0;
        end else if (clk_en_in) begin
            busy_cnt_q <= busy_cnt_q + TIMER_W'(1);
        end
    end

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    a_locked_no_chain: assert property (
        (unlock_q != UNLOCK_EN) && state_q == ST_IDLE && !busy_q
        |=> state_q == ST_IDLE && !busy_q)
        else $error("chain advanced while locked");
    a_busy_holds: assert property (
        busy_q && !done_w |=> busy_q && $stable(op_q))
        else $error("operation ended early or restarted");
    a_first_toggle_one: assert property (
        !busy_q ##1 busy_q |-> tog_q)
        else $error("first toggle read not one");
    a_toggle_flips: assert property (
        busy_q && rd_w && !done_w |=> rdata_q[6] == $past(tog_q)
        ##0 tog_q != $past(tog_q))
        else $error("busy bit did not toggle");
    a_prog_time: assert property (
        busy_q && op_q == OP_PROG |-> busy_cnt_q < TIMER_W'(PROG_CYC))
        else $error("program too long");
    a_secure_time: assert property (
        busy_q && op_q == OP_SEC |-> busy_cnt_q < TIMER_W'(SEC_CYC))
        else $error("security setting too long");
    a_chip_clears_prot: assert property (
        done_w && clk_en_in && op_q == OP_CHIP |=> !prot_q && !busy_q)
        else $error("chip erase left protection on");
    a_prot_only_chip: assert property (
        prot_q ##1 !prot_q |-> $past(done_w && op_q == OP_CHIP))
        else $error("protection cleared otherwise");
    a_secure_sets: assert property (
        done_w && clk_en_in && op_q == OP_SEC |=> prot_q)
        else $error("security did not set protection");
    a_id_exit_f0: assert property (
        id_q && wr_w && cmd_ok_w && state_q == ST_IDLE
        && data_w == CMD_ID_EXIT |=> !id_q)
        else $error("single exit write ignored");

    c_program:   cover property (busy_q && op_q == OP_PROG ##1 !busy_q);
    c_sector:    cover property (busy_q && op_q == OP_SECT ##1 !busy_q);
    c_chip:      cover property (prot_q && done_w && op_q == OP_CHIP);
    c_id_read:   cover property (id_q && rd_w && addr_w == ID_SIZE_ADDR);
endmodule : fcs_sequencer

// ==== verif/fcs_cpu_model.sv ====
`timescale 1ns/100ps
// ------------------------------------------------
// cpu bus master
// ------------------------------------------------
module fcs_cpu_model (
    // clock
    input  wire logic         sys_clk_in,
    // bus
    input  wire logic [7:0]   rdata_in,
    output fcs_pkg::fcs_bus_t bus_out
);
    import fcs_pkg::*;
    initial bus_out = '0;
    // released lines show inverted values
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        bus_out <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk_in);
        bus_out <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
        // status outputs settle before the caller looks at them
        @(negedge sys_clk_in);
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge sys_clk_in);
        bus_out <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge sys_clk_in);
        bus_out <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
        @(negedge sys_clk_in);
        d = rdata_in;
    endtask : rd
    // done once two reads of one address match
    task automatic poll(input logic [15:0] a, input int lim, output bit ok);
        logic [7:0] x;
        logic [7:0] y;
        ok = 1'b0;
        for (int i = 0; i < lim && !ok; i++) begin
            rd(a, x);
            rd(a, y);
            ok = (x === y) && !$isunknown(x);
        end
    endtask : poll
endmodule : fcs_cpu_model

// ==== verif/flash_command_sequencer_tb_top.sv ====
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
    $display("FAIL %s exp %h got %h", n, e, g); errors++; end end
module flash_command_sequencer_tb_top;
    import fcs_pkg::*;
    logic      sys_clk_in = 1'b0;
    logic      rst_n_in = 1'b0;
    logic      serial_boot_in = 1'b0;
    logic      parallel_mode_in = 1'b0;
    fcs_bus_t  bus;
    logic [7:0] rdata;
    logic      busy;
    logic      id_mode;
    logic      prot;
    logic      ldr_blk;
    logic [7:0] d;
    int        errors = 0;
    int        checked = 0;
    int        cyc = 0;
    int        t0;
    bit        ok;
    initial forever #50 sys_clk_in = ~sys_clk_in;
    always @(posedge sys_clk_in) cyc <= cyc + 1;
    fcs_cpu_model i_cpu (.sys_clk_in(sys_clk_in), .rdata_in(rdata), .bus_out(bus));
    fcs_sequencer #(.ERASE_CYC(16), .MAKER_CODE(8'h5a), .MACRO_CODE(8'h3c),
        .SIZE_CODE(SIZE_60K)) i_dut (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .clk_en_in(1'b1),
        .bus_in(bus), .rdata_out(rdata), .serial_boot_in(serial_boot_in),
        .parallel_mode_in(parallel_mode_in), .busy_out(busy), .id_mode_out(id_mode),
        .protect_out(prot), .loader_block_out(ldr_blk));
    task automatic stop_test();
        if (errors == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    task automatic chain2(input logic [3:0] hi);
        i_cpu.wr({hi, UNLK_ADDR1}, CMD_UNLK1);
        i_cpu.wr({hi, UNLK_ADDR2}, CMD_UNLK2);
    endtask : chain2
    task automatic chain3(input logic [3:0] hi, input logic [7:0] c);
        chain2(hi);
        i_cpu.wr({hi, UNLK_ADDR1}, c);
    endtask : chain3
    task automatic done(input logic [15:0] a, input int lim);
        i_cpu.poll(a, lim, ok);
        if (!ok) begin
            errors++;
            stop_test();
        end
    endtask : done
    task automatic prog(input logic [15:0] a, input logic [7:0] v);
        chain3(4'h7, CMD_PROG);
        i_cpu.wr(a, v);
        done(a, 200);
    endtask : prog
    task automatic sect(input logic [15:0] a);
        chain3(4'h1, CMD_ERASE);
        chain2(4'h1);
        i_cpu.wr(a, CMD_SECT);
        done(16'h0100, 2000);
    endtask : sect
    // mode pins change on a rising edge, then pass the synchronisers
    task automatic set_mode(input logic par, input logic ser);
        @(posedge sys_clk_in);
        parallel_mode_in <= par;
        serial_boot_in   <= ser;
        repeat (4) @(posedge sys_clk_in);
        #1;
    endtask : set_mode
    initial begin
        repeat (8) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        i_cpu.rd(CTRL_ADDR, d);
        `CHK("ctrl", 8'hc8, d)
        chain3(4'h7, CMD_PROG);
        i_cpu.wr(16'h1234, 8'h00);
        `CHK("locked", 1'b0, busy)
        i_cpu.wr(CTRL_ADDR, 8'h38);
        i_cpu.wr(16'h1555, CMD_UNLK1);
        i_cpu.wr(16'h1aaa, 8'h56);
        i_cpu.wr(16'h1555, CMD_ID_ENTRY);
        `CHK("bad chain", 1'b0, id_mode)
        chain3(4'h1, CMD_ID_ENTRY);
        `CHK("id in", 1'b1, id_mode)
        i_cpu.rd(ID_MAKER_ADDR, d);
        `CHK("maker", 8'h5a, d)
        i_cpu.rd(ID_MACRO_ADDR, d);
        `CHK("macro", 8'h3c, d)
        i_cpu.rd(ID_SIZE_ADDR, d);
        `CHK("size", SIZE_60K, d)
        i_cpu.rd(SEC_ADDR, d);
        `CHK("unprot", ERASED_BYTE, d)
        i_cpu.wr(16'h1000, CMD_ID_EXIT);
        `CHK("id exit1", 1'b0, id_mode)
        chain3(4'h1, CMD_ID_ENTRY);
        chain3(4'h1, CMD_ID_EXIT);
        `CHK("id exit3", 1'b0, id_mode)
        // array not yet erased: poll a defined non-flash address
        chain3(4'h1, CMD_SECURE);
        i_cpu.wr(SEC_ADDR, SEC_DATA);
        t0 = cyc;
        i_cpu.rd(16'h0100, d);
        `CHK("sec t1", 1'b1, d[6])
        done(16'h0100, 200);
        `CHK("sec time", 1'b1, cyc - t0 <= SEC_CYC + 8)
        `CHK("prot", 1'b1, prot)
        chain3(4'h1, CMD_ID_ENTRY);
        i_cpu.rd(SEC_ADDR, d);
        `CHK("prot id", PROT_ON_BYTE, d)
        i_cpu.wr(16'h1000, CMD_ID_EXIT);
        sect(16'h1abc);
        `CHK("prot kept", 1'b1, prot)
        set_mode(1'b1, 1'b0);
        i_cpu.rd(16'h1234, d);
        `CHK("par read", REFUSED_BYTE, d)
        set_mode(1'b0, 1'b1);
        `CHK("loader", 1'b1, ldr_blk)
        chain3(4'h9, CMD_PROG);
        i_cpu.wr(16'h9234, 8'h00);
        `CHK("ser prog", 1'b0, busy)
        chain3(4'h9, CMD_ERASE);
        chain3(4'h9, CMD_CHIP);
        i_cpu.rd(16'h9234, d);
        `CHK("chip t1", 1'b1, d[6])
        done(16'h9234, 20000);
        `CHK("chip unprot", 1'b0, prot)
        i_cpu.rd(16'hfedc, d);
        `CHK("blank", ERASED_BYTE, d)
        i_cpu.wr(CTRL_ADDR, 8'h30);
        chain3(4'h9, CMD_PROG);
        i_cpu.wr(16'hf000, 8'h3f);
        done(16'hf000, 200);
        set_mode(1'b0, 1'b0);
        i_cpu.rd(16'h7000, d);
        `CHK("bank0", 8'h3f, d)
        chain3(4'h5, CMD_PROG);
        i_cpu.wr(16'h1234, 8'h3c);
        t0 = cyc;
        i_cpu.rd(16'h1234, d);
        `CHK("prog t1", 1'b1, d[6])
        i_cpu.rd(16'h1234, d);
        `CHK("prog t2", 1'b0, d[6])
        chain3(4'h1, CMD_ID_ENTRY);
        done(16'h1234, 200);
        `CHK("prog time", 1'b1, cyc - t0 <= PROG_CYC + 8)
        `CHK("busy chain", 1'b0, id_mode)
        i_cpu.rd(16'h1234, d);
        `CHK("prog data", 8'h3c, d)
        prog(16'h2345, 8'h5a);
        sect(16'h1abc);
        i_cpu.rd(16'h1234, d);
        `CHK("sect", ERASED_BYTE, d)
        i_cpu.rd(16'h2345, d);
        `CHK("sect keep", 8'h5a, d)
        stop_test();
    end
endmodule : flash_command_sequencer_tb_top
